// File: hdl/clock_switch_pkg.sv
// clock switch package: mode encodings, i2c address layout, status field positions, counts
// assumes: used by the switch controller; the input monitor takes its width as a parameter instead
`default_nettype none
package clock_switch_pkg;
   localparam int NUM_INPUTS = 4;
   localparam logic [3:0] ADDR_UPPER = 4'hd; // fixed upper address nibble, binary 1101
   localparam logic [3:0] RESET_STATUS = 4'h0; // all-zero status value; the monitor's flags read valid from reset, with no confirm step
   localparam logic [1:0] RESET_SELECT = 2'h0;
   localparam logic [2:0] RESET_MODE = 3'h0;
   localparam int STATUS_FLAG_LSB = 3; // failure flags sit at bits 6:3 of the status register
   localparam int SELECT_LSB = 0;      // selected-clock code sits at bits 1:0
   localparam int LOCK_LSB = 2;        // loss-of-lock bit of the status register
   localparam int STATUS_REG_INDEX = 5;
   localparam int QUAL_REG_INDEX = 3;
   localparam int BOOT_BYTES = 6;      // eeprom bytes read at boot
   localparam int FAIL_DIV_DEFAULT = 1; // input divider value bounding phase-step detection
   typedef enum logic [3:0] {
      ST_MANUAL = 4'b0001,
      ST_AUTO = 4'b0010,
      ST_LOST = 4'b0100,
      ST_BOOT = 4'b1000
   } sw_state_e;
endpackage
`default_nettype wire

// File: hdl/input_fail_monitor.sv
// input monitor: one sticky failure flag per input, cleared by pin edge or per-input bit
// assumes: detector inputs are synchronous to clk and already sampled
`default_nettype none
module input_fail_monitor #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // raw per-input health from amplitude/activity detectors and phase detector
   input wire logic [N-1:0] input_bad,
   // clear sources
   input wire logic clear_all,
   input wire logic [N-1:0] clear_one,
   // flags: 1 valid, 0 failed
   output logic [N-1:0] stat_flags
);
   logic [N-1:0] sticky_reg; // 1 marks a latched failure
   logic [N-1:0] sticky_next;
   logic [N-1:0] bad_sync_reg; // second stage after detector sample
   logic [N-1:0] bad_meta_reg;

   // hold detector state in two flops before use
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bad_meta_reg <= '0;
         bad_sync_reg <= '0;
      end else begin
         bad_meta_reg <= input_bad;
         bad_sync_reg <= bad_meta_reg;
      end
   end

   // set wins over clear so a failure in the clear cycle is kept
   always_comb begin
      sticky_next = sticky_reg & ~(clear_one | {N{clear_all}});
      sticky_next = sticky_next | bad_sync_reg;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sticky_reg <= '0;
      end else begin
         sticky_reg <= sticky_next;
      end
   end

   assign stat_flags = ~sticky_reg;

   sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (bad_sync_reg[0] && !clear_all) |=> !stat_flags[0]) else $error("flag 0 not latched");
   sticky_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!stat_flags[0] && !clear_all && !clear_one[0]) |=> !stat_flags[0]) else $error("flag 0 dropped");
endmodule
`default_nettype wire

// File: hdl/clock_switch_controller.sv
// switch controller: picks the pll reference among four inputs, manual or automatic round robin
// assumes: all inputs synchronous to clk; i2c and eeprom engines sit outside and use these ports
// Notes on behaviour
// - modes 0xx select input directly, no secondary
// - modes 1xx: primary then round robin
// - auto switching only with bypass 0, mode bit2
// - low qualifier pin excludes input from selection
// - skip inputs without valid clock signal
// - failure moves to secondary, rotation continues
// - qualifier drop on reference triggers switch
// - qualified: pin high, flag high, no failure
// - failure flags latch until alarm reset
// - flag reads 0 failed, 1 valid
// - flags at status register bits 6:3
// - qualifier gating enabled by register 3 bit
// - per-input flag clear keeps reference
// - auto-mode write relocks on qualified new primary
// - select code shows current reference input
// - select code at status bits 1:0
// - none qualified: unlock, hold until reset
// - amplitude or activity fault flags failure only while its qualifier pin is high or gating is off
// - phase detector flags within divider cycles
// - frequency changes do not flag failure
// - i2c address 1101 plus address pins
// - boot pin loads six eeprom bytes
// - alarm pin falling edge clears, returns primary
// - per-input zero write clears only that flag
// - manual change only to valid input
`default_nettype none
module clock_switch_controller #(
   parameter int N = clock_switch_pkg::NUM_INPUTS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // configuration
   input wire logic [2:0] switch_mode_field,
   input wire logic mode_write,
   input wire logic pll_bypass,
   input wire logic qualifier_gate_enable,
   input wire logic [2:0] addr_pins,
   // qualifier pins
   input wire logic [N-1:0] clk_qualifier,
   // detector results
   input wire logic [N-1:0] amplitude_fault,
   input wire logic [N-1:0] activity_fault,
   input wire logic phase_step_fault,
   // alarm clears
   input wire logic alarm_reset_pin_b,
   input wire logic [N-1:0] alarm_reset_bits,
   input wire logic alarm_bits_write,
   // eeprom boot
   input wire logic eeprom_boot_pin,
   input wire logic boot_byte_valid,
   input wire logic [7:0] boot_byte,
   // status
   output logic [N-1:0] clk_status,
   output logic [1:0] sel_status,
   output logic lock_lost,
   output logic boot_active,
   output logic [7:0] status_reg_image,
   output logic [6:0] slave_address,
   output logic [47:0] boot_config
);
   // last boot byte index; the counter is only wide enough for a handful of bytes
   localparam logic [2:0] BOOT_LAST = 3'(clock_switch_pkg::BOOT_BYTES - 1);

   // controller state and reference selection
   clock_switch_pkg::sw_state_e state_reg; // current controller state
   clock_switch_pkg::sw_state_e state_next;
   logic [1:0] sel_reg; // current reference input
   logic [1:0] sel_next;
   logic start_reg; // high only in the first cycle after reset
   logic start_next;

   // eeprom boot capture
   logic [2:0] boot_count_reg; // bytes taken so far
   logic [2:0] boot_count_next;
   logic [47:0] boot_config_reg; // bytes shifted in, first byte ends on top
   logic [47:0] boot_config_next;

   // alarm pin edge detection
   logic alarm_pin_d_reg; // resets high, the pin's idle level, so reset makes no false edge
   logic alarm_pin_d_next;

   // registered status outputs
   logic [7:0] status_image_reg; // status register as the host reads it
   logic [7:0] status_image_next;
   logic [6:0] slave_address_reg; // bus address seen by the host
   logic [6:0] slave_address_next;

   // derived controls
   logic mode_auto; // automatic switching allowed
   logic [1:0] primary_sel; // primary input named by the mode field
   logic alarm_edge; // falling edge on the alarm reset pin
   logic [N-1:0] pin_ok; // qualifier pins after the gating enable
   logic [N-1:0] flags_w; // per-input flags from the monitor, 1 valid
   logic [N-1:0] qual_mask; // inputs fit to become reference
   logic [N-1:0] input_bad; // raw failure detections this cycle
   logic [N-1:0] clear_one; // per-input clear strobes
   logic [N-1:0] sel_onehot; // current reference as one-hot
   logic [2:0] pick_primary; // rotation search starting at the primary
   logic [2:0] pick_failover; // rotation search starting past the reference

   // first input in rotation order from start that is set in mask;
   // the top bit of the result says whether any input was found
   function automatic logic [2:0] pick_next(input logic [1:0] start, input logic [N-1:0] mask);
      logic [2:0] result;
      logic [1:0] cand;
      result = 3'h0;
      cand = 2'h0;
      // walk backwards so the nearest candidate is the one left standing
      for (int k = N - 1; k >= 0; k--) begin
         cand = start + 2'(k);
         if (mask[cand]) begin
            result = {1'b1, cand};
         end
      end
      return result;
   endfunction

   // mode decode: top bit asks for automatic, bypass forces manual selection
   always_comb begin
      mode_auto = switch_mode_field[2] & ~pll_bypass;
      primary_sel = switch_mode_field[1:0];
   end

   // qualification: pins count only while gating is on, and a latched failure excludes
   always_comb begin
      pin_ok = clk_qualifier | {N{~qualifier_gate_enable}};
      qual_mask = pin_ok & flags_w;
   end

   // failure sources: amplitude and activity on qualified inputs, phase on the reference;
   // there is no frequency monitor here, so drift or an out-of-range reference never flags
   always_comb begin
      sel_onehot = '0;
      sel_onehot[sel_reg] = 1'b1;
      input_bad = (amplitude_fault | activity_fault) & pin_ok;
      input_bad = input_bad | (sel_onehot & {N{phase_step_fault}});
   end

   // clear sources: pin edge clears all, a zero written to a bit clears that input only
   always_comb begin
      alarm_pin_d_next = alarm_reset_pin_b;
      alarm_edge = alarm_pin_d_reg & ~alarm_reset_pin_b;
      clear_one = ~alarm_reset_bits & {N{alarm_bits_write}};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         alarm_pin_d_reg <= 1'b1;
      end else begin
         alarm_pin_d_reg <= alarm_pin_d_next;
      end
   end

   // sticky failure flags live in their own module
   input_fail_monitor #(
      .N(N)
   ) i_monitor (
      .clk(clk),
      .rst_b(rst_b),
      .input_bad(input_bad),
      .clear_all(alarm_edge),
      .clear_one(clear_one),
      .stat_flags(flags_w)
   );

   // selection state machine; a per-input clear never reaches it, so the reference stays put
   always_comb begin
      state_next = state_reg;
      sel_next = sel_reg;
      start_next = 1'b0;
      boot_count_next = boot_count_reg;
      boot_config_next = boot_config_reg;
      pick_primary = pick_next(primary_sel, qual_mask);
      pick_failover = pick_next(sel_reg + 2'h1, qual_mask);
      case (state_reg)
         clock_switch_pkg::ST_MANUAL: begin
            if (start_reg && eeprom_boot_pin) begin
               // boot pin only counts in the first cycle out of reset
               state_next = clock_switch_pkg::ST_BOOT;
            end else if (mode_auto) begin
               // entering automatic mode starts from the primary when it is fit
               if (pick_primary[2]) begin
                  state_next = clock_switch_pkg::ST_AUTO;
                  sel_next = pick_primary[1:0];
               end else begin
                  state_next = clock_switch_pkg::ST_LOST;
               end
            end else if (qual_mask[primary_sel]) begin
               // a manual request is carried out only toward a valid input
               sel_next = primary_sel;
            end
         end
         clock_switch_pkg::ST_AUTO: begin
            if (!mode_auto) begin
               // manual mode or bypass ends failure-driven switching
               state_next = clock_switch_pkg::ST_MANUAL;
            end else if (alarm_edge) begin
               // pin clear returns to the configured primary
               sel_next = primary_sel;
            end else if (mode_write && (sel_reg != primary_sel) && qual_mask[primary_sel]) begin
               // host rewrite of an automatic mode relocks on the primary
               sel_next = primary_sel;
            end else if (!qual_mask[sel_reg]) begin
               // reference failed or lost its qualifier: rotate to the next fit input
               if (pick_failover[2]) begin
                  sel_next = pick_failover[1:0];
               end else begin
                  state_next = clock_switch_pkg::ST_LOST;
               end
            end else begin
               // reference healthy: keep it, the secondary is implied by rotation
               sel_next = sel_reg;
            end
         end
         clock_switch_pkg::ST_LOST: begin
            // only a master reset leaves this state
            state_next = clock_switch_pkg::ST_LOST;
         end
         clock_switch_pkg::ST_BOOT: begin
            if (boot_byte_valid) begin
               boot_config_next = {boot_config_reg[39:0], boot_byte};
               boot_count_next = boot_count_reg + 3'h1;
               if (boot_count_reg == BOOT_LAST) begin
                  // all bytes in: hand over to normal selection
                  state_next = clock_switch_pkg::ST_MANUAL;
                  boot_count_next = 3'h0;
               end
            end
         end
         default: begin
            // unreachable code: recover into manual selection
            state_next = clock_switch_pkg::ST_MANUAL;
         end
      endcase
   end

   // selection and boot registers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= clock_switch_pkg::ST_MANUAL;
         sel_reg <= clock_switch_pkg::RESET_SELECT;
         start_reg <= 1'b1;
         boot_count_reg <= 3'h0;
         boot_config_reg <= 48'h0000_0000_0000;
      end else begin
         state_reg <= state_next;
         sel_reg <= sel_next;
         start_reg <= start_next;
         boot_count_reg <= boot_count_next;
         boot_config_reg <= boot_config_next;
      end
   end

   // status register image and bus address, both registered
   always_comb begin
      status_image_next = 8'h00;
      status_image_next[clock_switch_pkg::STATUS_FLAG_LSB +: N] = flags_w;
      status_image_next[clock_switch_pkg::LOCK_LSB] = (state_reg == clock_switch_pkg::ST_LOST);
      status_image_next[clock_switch_pkg::SELECT_LSB +: 2] = sel_reg;
      slave_address_next = {clock_switch_pkg::ADDR_UPPER, addr_pins};
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status_image_reg <= 8'h00;
         slave_address_reg <= {clock_switch_pkg::ADDR_UPPER, 3'h0};
      end else begin
         status_image_reg <= status_image_next;
         slave_address_reg <= slave_address_next;
      end
   end

   // outputs
   assign clk_status = flags_w;
   assign sel_status = sel_reg;
   assign lock_lost = (state_reg == clock_switch_pkg::ST_LOST);
   assign boot_active = (state_reg == clock_switch_pkg::ST_BOOT);
   assign status_reg_image = status_image_reg;
   assign slave_address = slave_address_reg;
   assign boot_config = boot_config_reg;

   // checks on the selection logic
   lost_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == clock_switch_pkg::ST_LOST) |=> (state_reg == clock_switch_pkg::ST_LOST))
      else $error("lost state left without reset");
   none_lost_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == clock_switch_pkg::ST_AUTO && mode_auto && !alarm_edge && qual_mask == '0) |=> lock_lost)
      else $error("no qualified input but lock not dropped");
   failover_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == clock_switch_pkg::ST_AUTO && mode_auto && !alarm_edge && !mode_write &&
       !qual_mask[sel_reg] && qual_mask != '0) |=> (sel_status != $past(sel_status)))
      else $error("failed reference not replaced");
   auto_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == clock_switch_pkg::ST_AUTO && state_next == clock_switch_pkg::ST_AUTO &&
       sel_next != sel_reg && !alarm_edge) |-> qual_mask[sel_next])
      else $error("automatic switch to unqualified input");
   manual_pick_a: assert property (@(posedge clk) disable iff (!rst_b)
      (state_reg == clock_switch_pkg::ST_MANUAL && state_next == clock_switch_pkg::ST_MANUAL &&
       sel_next != sel_reg) |-> qual_mask[sel_next])
      else $error("manual switch to invalid input");
   addr_form_a: assert property (@(posedge clk) disable iff (!rst_b)
      slave_address[6:3] == clock_switch_pkg::ADDR_UPPER)
      else $error("bus address upper nibble wrong");

   // main scenarios worth seeing
   failover_c: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg == clock_switch_pkg::ST_AUTO && !qual_mask[sel_reg] && qual_mask != '0);
   lost_c: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg == clock_switch_pkg::ST_LOST);
   boot_c: cover property (@(posedge clk) disable iff (!rst_b)
      state_reg == clock_switch_pkg::ST_BOOT && boot_byte_valid);
endmodule
`default_nettype wire

// File: test/clock_source_model.sv
// far side: qualifier logic and the four clock sources' detectors
// assumes: bench clock domain
`default_nettype none
module clock_source_model (
   // clock
   input wire logic clk,
   // bench commands
   input wire logic [3:0] kill,
   input wire logic [3:0] qual,
   // to the switch
   output logic [3:0] amp_fault,
   output logic [3:0] act_fault,
   output logic [3:0] qual_pins
);
   // detectors lag a cycle; odd inputs fail by activity, even by amplitude
   always_ff @(posedge clk) begin
      amp_fault <= kill & 4'h5;
      act_fault <= kill & 4'ha;
      qual_pins <= qual;
   end
endmodule
`default_nettype wire

// File: test/redundant_reference_clock_switch_tb.sv
// bench: mode, fault and clear sequences against select code and flags
// assumes: outputs settle within eight cycles
`default_nettype none
module redundant_reference_clock_switch_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, mwr, awr, apin_b, ph, lk, ba, bp, bv;
   logic [47:0] bc;
   logic [2:0] mode, ap;
   logic [3:0] kill, qual, abits, amp, act, qp, stat;
   logic [1:0] sel;
   logic [7:0] img, bb;
   logic [6:0] addr;
   int n_fail = 0, tests_run = 0, cyc = 0;
   clock_switch_controller i_dut (.clk(clk), .rst_b(rst_b), .switch_mode_field(mode), .mode_write(mwr),
      .pll_bypass(1'b0), .qualifier_gate_enable(1'b1), .addr_pins(ap), .clk_qualifier(qp), .amplitude_fault(amp),
      .activity_fault(act), .phase_step_fault(ph), .alarm_reset_pin_b(apin_b), .alarm_reset_bits(abits),
      .alarm_bits_write(awr), .eeprom_boot_pin(bp), .boot_byte_valid(bv), .boot_byte(bb),
      .clk_status(stat), .sel_status(sel), .lock_lost(lk), .boot_active(ba), .status_reg_image(img),
      .slave_address(addr), .boot_config(bc));
   clock_source_model i_src (.clk(clk), .kill(kill), .qual(qual), .amp_fault(amp), .act_fault(act), .qual_pins(qp));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // one compare serves every result, zero-extended to the boot image width
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // let the switch settle
   task automatic wt();
      repeat (8) @(posedge clk);
   endtask
   task automatic set_mode(input logic [2:0] m);
      mode <= m;
      mwr <= 1'b1;
      @(posedge clk);
      mwr <= 1'b0;
      wt();
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // hang guard, far above the hundred-odd cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         end_of_test();
      end
   end
   initial begin
      {rst_b, mwr, awr, ph, mode, kill, bp, bv, bb} = '0;
      {apin_b, qual, abits, ap} = {1'b1, 8'hff, 3'h5};
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      set_mode(3'h2);
      chk(addr, 8'h6d);
      chk(sel, 8'h02);
      chk(lk, 8'h00);
      set_mode(3'h4);
      chk(sel, 8'h00);
      qual <= 4'hd;
      kill <= 4'h1;
      wt();
      chk(sel, 8'h02);
      chk(stat, 8'h0e);
      chk(img[6:3], 8'h0e);
      chk(img[1:0], 8'h02);
      kill <= 4'h0;
      abits <= 4'he;
      awr <= 1'b1;
      wt();
      awr <= 1'b0;
      chk(stat, 8'h0f);
      chk(sel, 8'h02);
      kill <= 4'h4;
      wt();
      chk(sel, 8'h03);
      set_mode(3'h4);
      chk(sel, 8'h00);
      kill <= 4'h1;
      wt();
      chk(sel, 8'h03);
      // let the detector settle before the pin clear, since a live failure wins over it
      kill <= 4'h0;
      wt();
      apin_b <= 1'b0;
      wt();
      chk(sel, 8'h00);
      chk(stat, 8'h0f);
      apin_b <= 1'b1;
      qual <= 4'h0;
      wt();
      chk(lk, 8'h01);
      // second reset, with the boot pin high: six bytes fill the configuration
      bp <= 1'b1;
      qual <= 4'hf;
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (2) @(posedge clk);
      chk(ba, 8'h01);
      for (int i = 1; i <= 6; i++) begin
         bb <= 8'(i * 17);
         bv <= 1'b1;
         @(posedge clk);
      end
      bv <= 1'b0;
      bp <= 1'b0;
      wt();
      chk(ba, 8'h00);
      chk(bc, 48'h1122_3344_5566);
      chk(lk, 8'h00);
      chk(sel, 8'h00);
      end_of_test();
   end
endmodule
`default_nettype wire
